// [src/shrp_defines.vh]
// constants for the serial host register port
// assumes a 100 MHz core clock
`ifndef SHRP_DEFINES_VH
`define SHRP_DEFINES_VH
// link select strap codes
`define SHRP_LINK_I2C    2'h0
`define SHRP_LINK_SPI    2'h1
`define SHRP_LINK_UART   2'h2
// i2c slave addresses
`define SHRP_I2C_ADDR_A  7'h56
`define SHRP_I2C_ADDR_B  7'h65
// uart baud in bits per second, core clock in Hz, baud dividers in clk_sys cycles
`define SHRP_CLK_HZ      100000000
`define SHRP_BAUD_MIN    1200
`define SHRP_BAUD_MAX    115200
`define SHRP_BAUD_DEF    9600
`define SHRP_BAUD_DIV_DEF 17'h028b0
`define SHRP_BAUD_DIV_MIN 17'h00364
`define SHRP_BAUD_DIV_MAX 17'h14585
// character layout
`define SHRP_CHR_BITS    9
`define SHRP_CHR_CMD     8
`define SHRP_RW_BIT      7
`define SHRP_GAP_DEF     8'h00
`endif

// [src/shrp_sync.v]
// two-flop synchroniser for one pin
// assumes input from outside the clk_sys domain
`timescale 1ns/10ps
module shrp_sync (
    clk_sys,
    rst,
    din,
    dout
);
    input  wire clk_sys;
    input  wire rst;
    input  wire din;
    output wire dout;

    reg meta_ff;
    reg sync_ff;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end
    assign dout = sync_ff;
endmodule

// [src/shrp_uart_tx.v]
// nine-bit async transmitter with programmable gap
// assumes baud divider and gap held stable in clk_sys domain
`timescale 1ns/10ps
`include "shrp_defines.vh"
module shrp_uart_tx (
    clk_sys,
    rst,
    baud_div,
    gap_bits,
    send,
    data,
    busy,
    txd
);
    input  wire        clk_sys;
    input  wire        rst;
    input  wire [16:0] baud_div;
    input  wire [7:0]  gap_bits;
    input  wire        send;
    input  wire [8:0]  data;
    output wire        busy;
    output reg         txd;

    reg [16:0] cnt_ff;
    reg [3:0]  bit_ff;
    reg [10:0] shf_ff;
    reg [7:0]  gap_ff;
    reg        act_ff;
    reg        gapf_ff;
    wire       tick;

    assign tick = (cnt_ff == 17'h00000);
    assign busy = act_ff | gapf_ff;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_ff  <= 17'h00000;
            bit_ff  <= 4'h0;
            shf_ff  <= 11'h7ff;
            gap_ff  <= 8'h00;
            act_ff  <= 1'b0;
            gapf_ff <= 1'b0;
            txd     <= 1'b1;
        end else if (!busy) begin
            if (send) begin
                // start low, nine bits lsb first, stop high
                shf_ff <= {1'b1, data, 1'b0};
                act_ff <= 1'b1;
                bit_ff <= 4'h0;
                cnt_ff <= 17'h00000;
            end
        end else if (tick) begin
            cnt_ff <= baud_div - 17'h00001;
            if (act_ff) begin
                txd    <= shf_ff[0];
                shf_ff <= {1'b1, shf_ff[10:1]};
                bit_ff <= bit_ff + 4'h1;
                if (bit_ff == 4'hb) begin
                    txd     <= 1'b1;
                    act_ff  <= 1'b0;
                    gapf_ff <= (gap_bits != 8'h00);
                    gap_ff  <= gap_bits;
                end
            end else begin
                // idle gap between read characters
                gap_ff <= gap_ff - 8'h01;
                if (gap_ff == 8'h01) begin
                    gapf_ff <= 1'b0;
                end
            end
        end else begin
            cnt_ff <= cnt_ff - 17'h00001;
        end
    end
endmodule

// [src/shrp_top.v]
// serial host register port: i2c, spi or nine-bit async slave
// assumes register file on clk_sys behind reg_* ports
`timescale 1ns/10ps
`include "shrp_defines.vh"
module shrp_top (
    clk_sys,
    rst,
    strap_link,
    strap_addr_sel,
    spi_cpol,
    spi_cpha,
    baud_div,
    baud_load,
    gap_bits,
    scl_in,
    sda_in,
    sda_out,
    sda_oe_n,
    cs_n_in,
    sck_in,
    serial_in_line,
    serial_out_line,
    rxd_in,
    txd_out,
    reg_addr,
    reg_wr,
    reg_rd,
    reg_wdata,
    reg_rdata,
    link_sel,
    baud_err
);
    input  wire       clk_sys;
    input  wire       rst;
    input  wire [1:0] strap_link;
    input  wire       strap_addr_sel;
    input  wire       spi_cpol;
    input  wire       spi_cpha;
    input  wire [16:0] baud_div;
    input  wire       baud_load;
    input  wire [7:0] gap_bits;
    input  wire       scl_in;
    input  wire       sda_in;
    output reg        sda_out;
    output reg        sda_oe_n;
    input  wire       cs_n_in;
    input  wire       sck_in;
    input  wire       serial_in_line;
    output reg        serial_out_line;
    input  wire       rxd_in;
    output reg        txd_out;
    output reg  [6:0] reg_addr;
    output reg        reg_wr;
    output reg        reg_rd;
    output reg  [7:0] reg_wdata;
    input  wire [7:0] reg_rdata;
    output reg  [1:0] link_sel;
    output reg        baud_err;

    // ==========================================================
    // strap capture
    reg       strap_done_ff;
    reg       addr_sel_ff;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strap_done_ff <= 1'b0;
            link_sel      <= `SHRP_LINK_I2C;
            addr_sel_ff   <= 1'b0;
        end else if (!strap_done_ff) begin
            // sampled once at release, then frozen
            strap_done_ff <= 1'b1;
            link_sel      <= strap_link;
            addr_sel_ff   <= strap_addr_sel;
        end
    end

    // ==========================================================
    // pin synchronisers
    wire [5:0] pin_raw;
    wire [5:0] pin_s;
    assign pin_raw = {rxd_in, serial_in_line, sck_in, cs_n_in, sda_in, scl_in};
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
            shrp_sync u_sync (
                .clk_sys (clk_sys),
                .rst     (rst),
                .din     (pin_raw[gi]),
                .dout    (pin_s[gi])
            );
        end
    endgenerate
    wire scl_s = pin_s[0];
    wire sda_s = pin_s[1];
    wire cs_s  = pin_s[2];
    wire sck_s = pin_s[3];
    wire si_s  = pin_s[4];
    wire rx_s  = pin_s[5];

    reg scl_d_ff;
    reg sda_d_ff;
    reg sck_d_ff;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            sck_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
            sck_d_ff <= sck_s;
        end
    end
    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    wire i2c_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire i2c_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    wire sck_rise = sck_s & ~sck_d_ff;
    wire sck_fall = ~sck_s & sck_d_ff;
    // modes 0/3 sample on rising, 1/2 on falling
    wire spi_smp = (spi_cpol ^ spi_cpha) ? sck_fall : sck_rise;
    wire spi_sht = (spi_cpol ^ spi_cpha) ? sck_rise : sck_fall;

    // ==========================================================
    // shared access strobes
    reg [6:0] nxt_addr;
    reg       nxt_wr;
    reg       nxt_rd;
    reg [7:0] nxt_wdata;

    // ==========================================================
    // i2c slave
    localparam I2_IDLE = 3'h0;
    localparam I2_DEV  = 3'h1;
    localparam I2_REG  = 3'h2;
    localparam I2_WDAT = 3'h3;
    localparam I2_RDAT = 3'h4;
    localparam I2_ACK  = 3'h5;
    localparam I2_MACK = 3'h6;
    reg [2:0] i2_st_ff;
    reg [2:0] i2_ret_ff;
    reg [3:0] i2_cnt_ff;
    reg [7:0] i2_sh_ff;
    reg [6:0] i2_addr_ff;
    reg       i2_wr_ff;
    reg       i2_wp_ff;
    reg       i2_rp_ff;
    wire [6:0] my_addr = addr_sel_ff ? `SHRP_I2C_ADDR_B : `SHRP_I2C_ADDR_A;
    wire i2_on = (link_sel == `SHRP_LINK_I2C) & strap_done_ff;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            i2_st_ff   <= I2_IDLE;
            i2_ret_ff  <= I2_IDLE;
            i2_cnt_ff  <= 4'h0;
            i2_sh_ff   <= 8'h00;
            i2_addr_ff <= 7'h00;
            i2_wr_ff   <= 1'b0;
            i2_wp_ff   <= 1'b0;
            i2_rp_ff   <= 1'b0;
            sda_out    <= 1'b1;
            sda_oe_n   <= 1'b1;
        end else begin
            i2_wp_ff <= 1'b0;
            i2_rp_ff <= 1'b0;
            if (!i2_on || i2c_stop) begin
                // stop ends any burst
                i2_st_ff <= I2_IDLE;
                sda_oe_n <= 1'b1;
            end else if (i2c_start) begin
                i2_st_ff  <= I2_DEV;
                i2_cnt_ff <= 4'h0;
                sda_oe_n  <= 1'b1;
            end else begin
                case (i2_st_ff)
                    I2_DEV, I2_REG, I2_WDAT: begin
                        if (scl_rise) begin
                            i2_sh_ff  <= {i2_sh_ff[6:0], sda_s};
                            i2_cnt_ff <= i2_cnt_ff + 4'h1;
                        end else if (scl_fall && i2_cnt_ff == 4'h8) begin
                            i2_cnt_ff <= 4'h0;
                            if (i2_st_ff == I2_DEV) begin
                                if (i2_sh_ff[7:1] == my_addr) begin
                                    i2_wr_ff  <= ~i2_sh_ff[0];
                                    i2_ret_ff <= i2_sh_ff[0] ? I2_RDAT : I2_REG;
                                    // read fetches from earlier address
                                    i2_rp_ff  <= i2_sh_ff[0];
                                    // slave drives ack low
                                    sda_out   <= 1'b0;
                                    sda_oe_n  <= 1'b0;
                                    i2_st_ff  <= I2_ACK;
                                end else begin
                                    i2_st_ff <= I2_IDLE;
                                end
                            end else begin
                                if (i2_st_ff == I2_REG) begin
                                    i2_addr_ff <= i2_sh_ff[6:0];
                                end else begin
                                    i2_wp_ff <= 1'b1;
                                end
                                i2_ret_ff <= I2_WDAT;
                                sda_out   <= 1'b0;
                                sda_oe_n  <= 1'b0;
                                i2_st_ff  <= I2_ACK;
                            end
                        end
                    end
                    I2_ACK: begin
                        if (scl_fall) begin
                            i2_st_ff <= i2_ret_ff;
                            if (i2_ret_ff == I2_RDAT) begin
                                i2_sh_ff <= {reg_rdata[6:0], 1'b1};
                                sda_out  <= reg_rdata[7];
                                sda_oe_n <= 1'b0;
                                i2_cnt_ff <= 4'h1;
                            end else begin
                                sda_oe_n <= 1'b1;
                            end
                        end
                    end
                    I2_RDAT: begin
                        if (scl_fall) begin
                            if (i2_cnt_ff == 4'h8) begin
                                sda_oe_n <= 1'b1;
                                i2_st_ff <= I2_MACK;
                            end else begin
                                sda_out   <= i2_sh_ff[7];
                                i2_sh_ff  <= {i2_sh_ff[6:0], 1'b1};
                                i2_cnt_ff <= i2_cnt_ff + 4'h1;
                            end
                        end
                    end
                    I2_MACK: begin
                        if (scl_rise) begin
                            // host ack keeps burst at same address
                            i2_st_ff <= sda_s ? I2_IDLE : I2_ACK;
                            i2_ret_ff <= I2_RDAT;
                            i2_rp_ff  <= ~sda_s;
                        end
                    end
                    default: i2_st_ff <= I2_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // spi slave
    reg [3:0] sp_cnt_ff;
    reg [7:0] sp_sh_ff;
    reg [7:0] sp_tx_ff;
    reg       sp_cmd_ff;
    reg       sp_rd_ff;
    reg [6:0] sp_addr_ff;
    reg       sp_wp_ff;
    reg       sp_rp_ff;
    wire sp_on = (link_sel == `SHRP_LINK_SPI) & strap_done_ff & ~cs_s;
    wire [7:0] sp_byte = {sp_sh_ff[6:0], si_s};

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sp_cnt_ff       <= 4'h0;
            sp_sh_ff        <= 8'h00;
            sp_tx_ff        <= 8'h00;
            sp_cmd_ff       <= 1'b1;
            sp_rd_ff        <= 1'b0;
            sp_addr_ff      <= 7'h00;
            sp_wp_ff        <= 1'b0;
            sp_rp_ff        <= 1'b0;
            serial_out_line <= 1'b1;
        end else begin
            sp_wp_ff <= 1'b0;
            sp_rp_ff <= 1'b0;
            if (!sp_on) begin
                sp_cnt_ff <= 4'h0;
                sp_cmd_ff <= 1'b1;
                sp_rd_ff  <= 1'b0;
            end else begin
                if (spi_smp) begin
                    sp_sh_ff <= sp_byte; // msb first
                    if (sp_cnt_ff == 4'h7) begin
                        sp_cnt_ff <= 4'h0;
                        if (sp_cmd_ff) begin
                            // address a6..a0 then rw bit
                            sp_addr_ff <= sp_byte[7:1];
                            sp_rd_ff   <= sp_byte[0];
                            sp_rp_ff   <= sp_byte[0];
                            sp_cmd_ff  <= 1'b0;
                        end else if (!sp_rd_ff) begin
                            sp_wp_ff <= 1'b1;
                        end else begin
                            sp_rp_ff <= 1'b1;
                        end
                    end else begin
                        sp_cnt_ff <= sp_cnt_ff + 4'h1;
                    end
                end
                if (spi_sht && sp_rd_ff) begin
                    if (sp_cnt_ff == 4'h0) begin
                        serial_out_line <= reg_rdata[7];
                        sp_tx_ff        <= {reg_rdata[6:0], 1'b0};
                    end else begin
                        serial_out_line <= sp_tx_ff[7];
                        sp_tx_ff        <= {sp_tx_ff[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // ==========================================================
    // async link
    reg [16:0] bd_ff;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bd_ff    <= `SHRP_BAUD_DIV_DEF;
            baud_err <= 1'b0;
        end else if (baud_load) begin
            // out of range divisors rejected
            if (baud_div >= `SHRP_BAUD_DIV_MIN && baud_div <= `SHRP_BAUD_DIV_MAX) begin
                bd_ff    <= baud_div;
                baud_err <= 1'b0;
            end else begin
                baud_err <= 1'b1;
            end
        end
    end

    reg [16:0] rc_ff;
    reg [3:0]  rb_ff;
    reg [8:0]  rs_ff;
    reg        rbusy_ff;
    reg        ur_wp_ff;
    reg        ur_rd_ff;
    reg        ur_go_ff;
    reg [6:0]  ur_addr_ff;
    wire ur_on = (link_sel == `SHRP_LINK_UART) & strap_done_ff;
    wire ur_tx_busy;
    wire ur_tx_go = ur_go_ff & ~ur_tx_busy & (reg_addr == ur_addr_ff);
    wire ur_txd;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rc_ff      <= 17'h00000;
            rb_ff      <= 4'h0;
            rs_ff      <= 9'h000;
            rbusy_ff   <= 1'b0;
            ur_wp_ff   <= 1'b0;
            ur_rd_ff   <= 1'b0;
            ur_go_ff   <= 1'b0;
            ur_addr_ff <= 7'h00;
        end else begin
            ur_wp_ff <= 1'b0;
            if (!ur_on) begin
                rbusy_ff <= 1'b0;
            end else if (!rbusy_ff) begin
                if (!rx_s) begin
                    rbusy_ff <= 1'b1;
                    rc_ff    <= {1'b0, bd_ff[16:1]};
                    rb_ff    <= 4'h0;
                end
            end else if (rc_ff != 17'h00000) begin
                rc_ff <= rc_ff - 17'h00001;
            end else begin
                rc_ff <= bd_ff - 17'h00001;
                rb_ff <= rb_ff + 4'h1;
                if (rb_ff == 4'h0) begin
                    rbusy_ff <= ~rx_s;
                end else if (rb_ff <= 4'h9) begin
                    rs_ff <= {rx_s, rs_ff[8:1]}; // lsb first
                end else begin
                    rbusy_ff <= 1'b0;
                    if (rx_s) begin
                        if (rs_ff[`SHRP_CHR_CMD]) begin
                            ur_addr_ff <= rs_ff[6:0];
                            ur_rd_ff   <= rs_ff[`SHRP_RW_BIT];
                            ur_go_ff   <= rs_ff[`SHRP_RW_BIT];
                        end else if (!ur_rd_ff) begin
                            ur_wp_ff <= 1'b1;
                        end
                    end
                end
            end
            if (ur_tx_go) begin
                ur_go_ff <= 1'b0;
            end
        end
    end

    // one character returned per read command
    shrp_uart_tx u_tx (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .baud_div (bd_ff),
        .gap_bits (gap_bits),
        .send     (ur_tx_go),
        .data     ({1'b0, reg_rdata}),
        .busy     (ur_tx_busy),
        .txd      (ur_txd)
    );

    // ==========================================================
    // register access merge
    always @* begin
        nxt_addr  = reg_addr;
        nxt_wr    = 1'b0;
        nxt_rd    = 1'b0;
        nxt_wdata = reg_wdata;
        case (link_sel)
            `SHRP_LINK_I2C: begin
                nxt_addr  = i2_addr_ff;
                nxt_wr    = i2_wp_ff;
                nxt_rd    = i2_rp_ff;
                nxt_wdata = i2_sh_ff;
            end
            `SHRP_LINK_SPI: begin
                nxt_addr  = sp_addr_ff;
                nxt_wr    = sp_wp_ff;
                nxt_rd    = sp_rp_ff;
                nxt_wdata = sp_sh_ff;
            end
            `SHRP_LINK_UART: begin
                nxt_addr  = ur_addr_ff;
                nxt_wr    = ur_wp_ff;
                nxt_rd    = ur_tx_go;
                nxt_wdata = rs_ff[7:0];
            end
            default: begin
                nxt_wr = 1'b0;
            end
        endcase
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_addr  <= 7'h00;
            reg_wr    <= 1'b0;
            reg_rd    <= 1'b0;
            reg_wdata <= 8'h00;
            txd_out   <= 1'b1;
        end else begin
            reg_addr  <= nxt_addr;
            reg_wr    <= nxt_wr;
            reg_rd    <= nxt_rd;
            reg_wdata <= nxt_wdata;
            txd_out   <= ur_txd;
        end
    end
endmodule

// [sim/shrp_properties.sv]
// checker for the serial host register port
// assumes binding onto shrp_top, one clock domain
`timescale 1ns/10ps
`include "shrp_defines.vh"
module shrp_props (
    input wire        clk_sys,
    input wire        rst,
    input wire [16:0] baud_div,
    input wire        baud_load,
    input wire        cs_n_in,
    input wire        sda_oe_n,
    input wire        txd_out,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [1:0]  link_sel,
    input wire        baud_err
);
    // ==========
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_link_held: assert property (!$past(rst, 2) |-> $stable(link_sel))
        else $error("link type moved");
    a_link_code: assert property (link_sel != 2'h3)
        else $error("bad link type");
    a_sda_quiet: assert property (link_sel != `SHRP_LINK_I2C |-> sda_oe_n)
        else $error("sda driven off link");
    a_txd_quiet: assert property (link_sel != `SHRP_LINK_UART |-> txd_out)
        else $error("txd active off link");
    a_start_len: assert property ($fell(txd_out) |-> !txd_out [*8])
        else $error("start bit short");
    a_ack_hold: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*6])
        else $error("ack too short");
    a_baud_reject: assert property (baud_load && (baud_div < 17'd868 ||
        baud_div > 17'd83333) |-> ##[1:2] baud_err) else $error("baud not refused");
    a_spi_idle: assert property (link_sel == `SHRP_LINK_SPI && cs_n_in [*8]
        |-> !reg_wr && !reg_rd) else $error("strobe outside frame");
    c_write: cover property (reg_wr);
    c_read: cover property (reg_rd);
    c_ack: cover property ($fell(sda_oe_n));
    c_tx: cover property ($fell(txd_out));
endmodule
bind shrp_top shrp_props i_shrp_props (.clk_sys(clk_sys), .rst(rst), .baud_div(baud_div),
    .baud_load(baud_load), .cs_n_in(cs_n_in), .sda_oe_n(sda_oe_n), .txd_out(txd_out),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .link_sel(link_sel), .baud_err(baud_err));

// [sim/shrp_host_model.sv]
// host side spi master
// assumes clk_sys at 100 MHz, link half period 8 cycles
`timescale 1ns/10ps
module shrp_host_model (
    input  wire clk_sys,
    input  wire cpol,
    input  wire cpha,
    input  wire sout,
    output reg  cs_n,
    output reg  sck,
    output reg  sin
);
    // =====
    // frames
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sin = 1'b0;
    end
    task half;
        repeat (8) @(posedge clk_sys);
        #1;
    endtask
    task open;
        sck = cpol; // idle level
        half;
        cs_n = 1'b0;
        half;
    endtask
    task close;
        half;
        cs_n = 1'b1;
        sin = ~sin; // line inverted while deselected
        half;
    endtask
    task xfer(input [7:0] b, output [7:0] r);
        integer k;
        for (k = 7; k >= 0; k = k - 1) begin
            if (cpha) sck = ~cpol;
            sin = b[k]; // msb first
            half;
            sck = ~sck; // sample edge
            r[k] = sout;
            half;
            if (!cpha) sck = cpol;
        end
    endtask
endmodule

// [sim/shrp_top_tb.sv]
// bench for the serial host register port
// assumes shrp_top and shrp_host_model
`timescale 1ns/10ps
`include "shrp_defines.vh"
module shrp_top_tb;
    reg         clk_sys = 1'b0;
    reg         rst = 1'b1;
    reg  [1:0]  strap_link = 2'h1;
    reg         strap_addr_sel = 1'b0;
    reg         spi_cpol = 1'b0;
    reg         spi_cpha = 1'b0;
    reg  [16:0] baud_div = 17'd868;
    reg         baud_load = 1'b0;
    reg  [7:0]  gap_bits = 8'h00;
    reg         hscl = 1'b1;
    reg         hsda = 1'b1;
    reg         rxd_in = 1'b1;
    wire        sda_out, sda_oe_n, cs_n, sck, sin, sout, txd_out, reg_wr, reg_rd, baud_err;
    wire [6:0]  reg_addr;
    wire [7:0]  reg_wdata;
    wire [1:0]  link_sel;
    wire        sda_w = hsda & (sda_oe_n | sda_out);
    wire [7:0]  reg_rdata = {1'b0, reg_addr} ^ 8'ha5;
    logic [15:0] notes[$];
    integer     bad_count = 0;
    integer     n_compared = 0;
    integer     i, j, m;
    reg  [6:0]  a;
    reg  [7:0]  d, r;
    reg  [8:0]  u;
    always #5 clk_sys = ~clk_sys;
    shrp_top i_shrp_top (.clk_sys(clk_sys), .rst(rst), .strap_link(strap_link),
        .strap_addr_sel(strap_addr_sel), .spi_cpol(spi_cpol), .spi_cpha(spi_cpha),
        .baud_div(baud_div), .baud_load(baud_load), .gap_bits(gap_bits), .scl_in(hscl),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cs_n_in(cs_n), .sck_in(sck),
        .serial_in_line(sin), .serial_out_line(sout), .rxd_in(rxd_in), .txd_out(txd_out),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .link_sel(link_sel), .baud_err(baud_err));
    shrp_host_model i_shrp_host_model (.clk_sys(clk_sys), .cpol(spi_cpol), .cpha(spi_cpha),
        .sout(sout), .cs_n(cs_n), .sck(sck), .sin(sin));
    // =====
    // tasks
    task chk(input [15:0] seen, input [15:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task half;
        repeat (8) @(posedge clk_sys);
        #1;
    endtask
    task bitt;
        repeat (868) @(posedge clk_sys);
        #1;
    endtask
    task restart(input [1:0] link);
        rst = 1'b1;
        strap_link = link;
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task ibyte(input [7:0] b, input ack);
        for (i = 7; i >= 0; i = i - 1) begin
            hsda = b[i];
            half;
            hscl = 1'b1;
            half;
            hscl = 1'b0;
        end
        hsda = 1'b1;
        half;
        hscl = 1'b1;
        half;
        chk({15'h0, sda_w}, {15'h0, ~ack}); // ack level
        hscl = 1'b0;
    endtask
    task uchar(input [8:0] c);
        rxd_in = 1'b0; // start low
        bitt;
        for (i = 0; i < 9; i = i + 1) begin
            rxd_in = c[i]; // lsb first
            bitt;
        end
        rxd_in = 1'b1;
        bitt;
    endtask
    task urx;
        j = 0;
        while (txd_out === 1'b1 && j < 40000) begin
            @(posedge clk_sys);
            j = j + 1;
        end
        repeat (434) @(posedge clk_sys);
        chk({15'h0, txd_out}, 16'h0); // start bit
        for (j = 0; j < 9; j = j + 1) begin
            repeat (868) @(posedge clk_sys);
            u[j] = txd_out;
        end
        repeat (868) @(posedge clk_sys);
        chk({15'h0, txd_out}, 16'h1); // stop bit
    endtask
    task bload(input [16:0] v, input e);
        baud_div = v;
        baud_load = 1'b1;
        @(posedge clk_sys);
        #1;
        baud_load = 1'b0;
        repeat (3) @(posedge clk_sys);
        chk({15'h0, baud_err}, {15'h0, e}); // range
    endtask
    always @(posedge clk_sys) begin
        if (reg_wr === 1'b1 || reg_rd === 1'b1) begin
            if (notes.size() == 0)
                chk({reg_rd, reg_addr, reg_wdata}, 16'hxxxx);
            else
                chk({reg_rd, reg_addr, reg_rd ? 8'h00 : reg_wdata}, notes.pop_front());
        end
    end
    // =====
    // tests
    initial begin
        d = 8'($urandom(32'h446f3a83));
        restart(`SHRP_LINK_SPI);
        strap_link = `SHRP_LINK_UART;
        for (m = 0; m < 4; m = m + 1) begin
            {spi_cpol, spi_cpha} = m[1:0];
            a = 7'($urandom);
            d = 8'($urandom);
            notes.push_back({1'b0, a, d});
            notes.push_back({1'b0, a, ~d});
            repeat (3) notes.push_back({1'b1, a, 8'h00}); // command plus two bytes
            i_shrp_host_model.open;
            i_shrp_host_model.xfer({a, 1'b0}, r); // write command
            i_shrp_host_model.xfer(d, r);
            i_shrp_host_model.xfer(~d, r);
            i_shrp_host_model.close;
            i_shrp_host_model.open;
            i_shrp_host_model.xfer({a, 1'b1}, r);
            i_shrp_host_model.xfer(8'h00, r);
            chk({8'h0, r}, {8'h0, {1'b0, a} ^ 8'ha5}); // read data
            i_shrp_host_model.xfer(8'hff, r);
            chk({8'h0, r}, {8'h0, {1'b0, a} ^ 8'ha5}); // same address
            i_shrp_host_model.close;
        end
        chk({14'h0, link_sel}, {14'h0, `SHRP_LINK_SPI}); // strap kept
        strap_addr_sel = 1'($urandom);
        restart(`SHRP_LINK_I2C);
        notes.push_back({1'b0, a, d});
        notes.push_back({1'b0, a, ~d});
        hsda = 1'b0;
        half;
        hscl = 1'b0;
        ibyte({(strap_addr_sel ? `SHRP_I2C_ADDR_B : `SHRP_I2C_ADDR_A), 1'b0}, 1'b1);
        ibyte({1'b1, a}, 1'b1); // msb set
        ibyte(d, 1'b1);
        ibyte(~d, 1'b1);
        hsda = 1'b0;
        half;
        hscl = 1'b1;
        half;
        hsda = 1'b1;
        half;
        hsda = 1'b0;
        half;
        hscl = 1'b0;
        ibyte({(strap_addr_sel ? `SHRP_I2C_ADDR_A : `SHRP_I2C_ADDR_B), 1'b0}, 1'b0);
        ibyte(d, 1'b0); // ignored, other address selected
        chk(16'(notes.size()), 16'h0); // all strobes seen
        gap_bits = {6'h0, d[1:0]};
        restart(`SHRP_LINK_UART);
        bload(17'd868, 1'b0);
        bload(17'd867, 1'b1);
        notes.push_back({1'b0, a, d});
        notes.push_back({1'b1, a, 8'h00});
        uchar({2'b10, a}); // write command
        uchar({1'b0, d});
        fork
            uchar({2'b11, a});
            urx;
        join
        chk({7'h0, u}, {8'h0, {1'b0, a} ^ 8'ha5}); // reply char
        chk(16'(notes.size()), 16'h0); // all strobes seen
        conclude;
    end
    initial begin
        #1000000;
        bad_count = bad_count + 1;
        conclude;
    end
endmodule
